// File: logic/ppt_defs.svh
// constants for the single-dword programmed-io target
// assumes inclusion from the target and the memory module only
`ifndef PPT_DEFS_SVH
`define PPT_DEFS_SVH
`define PPT_DATA_W       64
`define PPT_BAR_LSB      112
`define PPT_BAR_MSB      114
`define PPT_ADDR_LSB     2
`define PPT_ADDR_MSB     10
`define PPT_WORD_AW      9
`define PPT_REGION_AW    2
`define PPT_LEN_LSB      64
`define PPT_LEN_MSB      74
`define PPT_TYPE_LSB     75
`define PPT_TYPE_MSB     78
`define PPT_TAG_LSB      96
`define PPT_TAG_MSB      103
`define PPT_BAR_IO       3'h0
`define PPT_BAR_MEM32    3'h2
`define PPT_BAR_MEM64    3'h1
`define PPT_BAR_EROM     3'h6
`define PPT_REQ_MRD      4'h0
`define PPT_REQ_MWR      4'h1
`define PPT_REQ_IORD     4'h2
`define PPT_REQ_IOWR     4'h3
`define PPT_ONE_DW       11'h001
`define PPT_FIFO_DEPTH   8
`endif

// File: logic/ppt_pkg.sv
// types shared by the programmed-io target modules
// assumes ppt_defs.svh is on the include path
`default_nettype none
package ppt_pkg;
  typedef enum logic [2:0] {
    PPT_RX_IDLE  = 3'b000,
    PPT_RX_BEAT2 = 3'b001,
    PPT_RX_EXEC  = 3'b011,
    PPT_RX_WAIT  = 3'b010,
    PPT_RX_DRAIN = 3'b110
  } ppt_rx_state_t;
  typedef struct packed {
    logic        is_read;
    logic        is_io;
    logic [7:0]  tag;
    logic [31:0] data;
  } ppt_cpl_t;
endpackage
`default_nettype wire

// File: logic/ppt_fifo_if.sv
// valid/ready carrier between the target and its completion fifo
// assumes one clock shared by both ends
`default_nettype none
interface ppt_fifo_if #(parameter int WIDTH = 42);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: logic/ppt_fifo.sv
// parameterised fifo; data output registered
// assumes synchronous active-high reset
`default_nettype none
module ppt_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 8
) (
  input  wire logic mclk_in,
  input  wire logic reset_in,
  ppt_fifo_if.snk   wr,
  ppt_fifo_if.src   rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wptr_q;
  logic [AW:0]      rptr_q;
  logic             full;
  logic             empty;
  logic             out_v_q;
  logic [WIDTH-1:0] out_q;
  logic             pop;
  assign full     = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign empty    = (wptr_q == rptr_q);
  assign wr.ready = !full;
  assign pop      = !empty && (!out_v_q || rd.ready);
  assign rd.valid = out_v_q;
  assign rd.data  = out_q;
  always_ff @(posedge mclk_in) begin
    if (wr.valid && !full) begin
      mem_q[wptr_q[AW-1:0]] <= wr.data;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wptr_q <= '0;
    end else if (wr.valid && !full) begin
      wptr_q <= wptr_q + 1'b1;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rptr_q  <= '0;
      out_v_q <= 1'b0;
      out_q   <= '0;
    end else begin
      if (pop) begin
        rptr_q  <= rptr_q + 1'b1;
        out_q   <= mem_q[rptr_q[AW-1:0]];
        out_v_q <= 1'b1;
      end else if (rd.ready) begin
        out_v_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/ppt_target.sv
// single-dword programmed-io target behind a pcie endpoint completer stream
// assumes 64-bit request/completion streams, descriptor in two beats, one clock
`default_nettype none
`include "ppt_defs.svh"
module ppt_target #(
  parameter int STREAM_W = `PPT_DATA_W // fixed 64-bit build, never the 128-bit x8 case
) (
  input  wire logic                  mclk_in,
  input  wire logic                  reset_in,
  input  wire logic [STREAM_W-1:0]   req_data_in,
  input  wire logic                  req_valid_in,
  input  wire logic                  req_last_in,
  output logic                       request_stream_accept_out,
  output logic [STREAM_W-1:0]        cpl_data_out,
  output logic                       cpl_valid_out,
  output logic                       cpl_last_out,
  input  wire logic                  cpl_ready_in,
  output logic                       compl_done_out,
  output logic                       write_pending_out,
  input  wire logic                  turnoff_req_in,
  output logic                       turnoff_ok_out
);
  localparam int CPLW = $bits(ppt_pkg::ppt_cpl_t);
  ppt_pkg::ppt_rx_state_t state_q;
  logic [127:0]           desc_q;
  logic                   beat_q;
  logic [2:0]             bar;
  logic [3:0]             rtype;
  logic [10:0]            rlen;
  logic                   one_dw;
  logic                   is_wr;
  logic                   is_io;
  logic [`PPT_REGION_AW+`PPT_WORD_AW-1:0] ram_addr_q;
  logic                   ram_we_q;
  logic                   ram_re_q;
  logic [31:0]            ram_wdata_q;
  logic [31:0]            ram_rdata;
  logic                   rd_valid_q;
  logic                   cpl_sent;
  logic                   pend_q;
  logic                   tx_busy_q;
  logic                   tx_beat_q;
  ppt_pkg::ppt_cpl_t      cpl_in;
  ppt_pkg::ppt_cpl_t      cpl_head;
  ppt_fifo_if #(.WIDTH(CPLW)) cq_wr ();
  ppt_fifo_if #(.WIDTH(CPLW)) cq_rd ();

  // region select from bar index; unmatched bars fall back to region zero
  function automatic logic [`PPT_REGION_AW-1:0] region_of(input logic [2:0] b);
    if (b == `PPT_BAR_IO) begin
      return 2'h0;
    end else if (b == `PPT_BAR_MEM32) begin
      return 2'h1;
    end else if (b == `PPT_BAR_MEM64) begin
      return 2'h2;
    end else if (b == `PPT_BAR_EROM) begin
      return 2'h3;
    end else begin
      return 2'h0;
    end
  endfunction

  // descriptor is assembled from two 64-bit beats; the core has matched the bar already
  assign bar    = desc_q[`PPT_BAR_MSB:`PPT_BAR_LSB];
  assign rtype  = desc_q[`PPT_TYPE_MSB:`PPT_TYPE_LSB];
  assign rlen   = desc_q[`PPT_LEN_MSB:`PPT_LEN_LSB];
  assign one_dw = (rlen == `PPT_ONE_DW);
  assign is_wr  = (rtype == `PPT_REQ_MWR) || (rtype == `PPT_REQ_IOWR);
  assign is_io  = (rtype == `PPT_REQ_IORD) || (rtype == `PPT_REQ_IOWR);

  // accept only when idle-ish; dropping it stalls the core during ram work
  assign request_stream_accept_out = (state_q == ppt_pkg::PPT_RX_IDLE) ||
                                     (state_q == ppt_pkg::PPT_RX_BEAT2) ||
                                     (state_q == ppt_pkg::PPT_RX_DRAIN);
  assign write_pending_out = ram_we_q;
  assign turnoff_ok_out    = turnoff_req_in && (state_q == ppt_pkg::PPT_RX_IDLE) && !pend_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q     <= ppt_pkg::PPT_RX_IDLE;
      desc_q      <= '0;
      ram_addr_q  <= '0;
      ram_wdata_q <= '0;
      ram_we_q    <= 1'b0;
      ram_re_q    <= 1'b0;
      pend_q      <= 1'b0;
    end else begin
      ram_we_q <= 1'b0;
      ram_re_q <= 1'b0;
      case (state_q)
        ppt_pkg::PPT_RX_IDLE: begin
          if (req_valid_in) begin
            desc_q[63:0] <= req_data_in[63:0];
            state_q      <= ppt_pkg::PPT_RX_BEAT2;
          end
        end
        ppt_pkg::PPT_RX_BEAT2: begin
          if (req_valid_in) begin
            desc_q[127:64] <= req_data_in[63:0];
            if (req_data_in[`PPT_LEN_MSB-64:`PPT_LEN_LSB-64] != `PPT_ONE_DW) begin
              state_q <= req_last_in ? ppt_pkg::PPT_RX_IDLE : ppt_pkg::PPT_RX_DRAIN;
            end else if (!req_last_in) begin
              state_q <= ppt_pkg::PPT_RX_DRAIN;
              desc_q[127:64] <= req_data_in[63:0];
            end else begin
              state_q <= ppt_pkg::PPT_RX_IDLE; // one-dword request without payload beat is dropped
            end
          end
        end
        ppt_pkg::PPT_RX_DRAIN: begin
          if (req_valid_in) begin
            if (one_dw && !pend_q) begin
              ram_wdata_q <= req_data_in[31:0];
              pend_q      <= 1'b1;
            end
            if (req_last_in) begin
              state_q <= (one_dw) ? ppt_pkg::PPT_RX_EXEC : ppt_pkg::PPT_RX_IDLE;
            end
          end
        end
        ppt_pkg::PPT_RX_EXEC: begin
          ram_addr_q <= {region_of(bar), desc_q[`PPT_ADDR_MSB:`PPT_ADDR_LSB]};
          pend_q     <= 1'b0;
          if (is_wr) begin
            ram_we_q <= 1'b1;
          end else begin
            ram_re_q <= 1'b1;
          end
          state_q <= ppt_pkg::PPT_RX_WAIT;
        end
        ppt_pkg::PPT_RX_WAIT: begin
          if (is_wr && !is_io && !ram_we_q) begin
            state_q <= ppt_pkg::PPT_RX_IDLE;
          end else if ((!is_wr || is_io) && cpl_sent) begin
            state_q <= ppt_pkg::PPT_RX_IDLE;
          end
        end
        default: begin
          state_q <= ppt_pkg::PPT_RX_IDLE;
        end
      endcase
    end
  end

  // payload is captured on the data beat; requests are one-beat data after the descriptor
  ppt_mem u_mem (
    .mclk_in   (mclk_in),
    .we_in     (ram_we_q),
    .re_in     (ram_re_q),
    .addr_in   (ram_addr_q),
    .wdata_in  (ram_wdata_q),
    .rdata_out (ram_rdata)
  );

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= ram_re_q;
    end
  end

  // completions queue up: reads with data, io writes without
  assign cpl_in.is_read = rd_valid_q;
  assign cpl_in.is_io   = is_io;
  assign cpl_in.tag     = desc_q[`PPT_TAG_MSB:`PPT_TAG_LSB];
  assign cpl_in.data    = rd_valid_q ? ram_rdata : 32'h0000_0000;
  assign cq_wr.valid    = rd_valid_q || (ram_we_q && is_io);
  assign cq_wr.data     = cpl_in;

  ppt_fifo #(.WIDTH(CPLW), .DEPTH(`PPT_FIFO_DEPTH)) u_cq (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .wr       (cq_wr.snk),
    .rd       (cq_rd.src)
  );

  // tx engine: two beats per completion, header then payload
  assign cpl_head       = cq_rd.data;
  assign cq_rd.ready    = tx_beat_q && cpl_ready_in;
  assign cpl_sent       = cq_rd.valid && cq_rd.ready;
  assign cpl_valid_out  = tx_busy_q;
  assign cpl_last_out   = tx_beat_q;
  assign compl_done_out = cpl_sent;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tx_busy_q <= 1'b0;
      tx_beat_q <= 1'b0;
    end else if (!tx_busy_q) begin
      tx_busy_q <= cq_rd.valid;
      tx_beat_q <= 1'b0;
    end else if (cpl_ready_in) begin
      tx_beat_q <= !tx_beat_q;
      tx_busy_q <= !tx_beat_q;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cpl_data_out <= '0;
    end else if (cq_rd.valid && (!tx_busy_q || (cpl_ready_in && !tx_beat_q))) begin
      if (!tx_busy_q) begin
        cpl_data_out <= {{(STREAM_W-12){1'b0}}, cpl_head.is_io, cpl_head.is_read, 10'h001};
      end else begin
        cpl_data_out <= {{(STREAM_W-40){1'b0}}, cpl_head.tag, cpl_head.data};
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/ppt_mem.sv
// four 2 kb regions as one 2048-word ram, registered read data
// assumes single clock, no reset on contents
`default_nettype none
`include "ppt_defs.svh"
module ppt_mem (
  input  wire logic                                   mclk_in,
  input  wire logic                                   we_in,
  input  wire logic                                   re_in,
  input  wire logic [`PPT_REGION_AW+`PPT_WORD_AW-1:0] addr_in,
  input  wire logic [31:0]                            wdata_in,
  output logic [31:0]                                 rdata_out
);
  logic [31:0] region_zero_memory [2**(`PPT_REGION_AW+`PPT_WORD_AW)];
  always_ff @(posedge mclk_in) begin
    if (we_in) begin
      region_zero_memory[addr_in] <= wdata_in;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (re_in) begin
      rdata_out <= region_zero_memory[addr_in];
    end
  end
endmodule
`default_nettype wire

// File: testbench/ppt_target_chk.sv
// port checker for the programmed-io target
// assumes a bind onto ppt_target built with a 64-bit stream
`default_nettype none
module ppt_target_chk (
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic [63:0] req_data_in,
  input wire logic        req_valid_in,
  input wire logic        req_last_in,
  input wire logic        request_stream_accept_out,
  input wire logic [63:0] cpl_data_out,
  input wire logic        cpl_valid_out,
  input wire logic        cpl_ready_in,
  input wire logic        compl_done_out,
  input wire logic        write_pending_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic [1:0]  b_q;
  logic [10:0] len_q;
  logic [3:0]  typ_q;
  logic        rd_q;
  wire logic   tk  = req_valid_in && request_stream_accept_out;
  wire logic   fin = tk && req_last_in && b_q == 2'h2;
  wire logic   one = len_q == 11'h001;
  wire logic   rdk = typ_q == 4'h0 || typ_q == 4'h2;
  always_ff @(posedge mclk_in) begin
    if (reset_in || (tk && req_last_in)) b_q <= 2'h0;
    else if (tk && b_q != 2'h2) b_q <= b_q + 2'h1;
  end
  always_ff @(posedge mclk_in) begin
    if (tk && b_q == 2'h1) begin
      len_q <= req_data_in[10:0];
      typ_q <= req_data_in[14:11];
    end
  end
  // set by an accepted read, cleared once its completion went out
  always_ff @(posedge mclk_in) begin
    if (reset_in || compl_done_out) rd_q <= 1'b0;
    else if (fin && one && rdk) rd_q <= 1'b1;
  end
  a_reset_idle: assert property ($fell(reset_in) |-> request_stream_accept_out && !cpl_valid_out)
    else $error("not idle after reset");
  a_last_stall: assert property (fin && one |=> !request_stream_accept_out)
    else $error("accept high after last beat");
  a_read_hold: assert property (rd_q && !compl_done_out |-> !request_stream_accept_out)
    else $error("accept high before completion sent");
  a_read_cpl: assert property (fin && one && rdk |-> ##[1:40] cpl_valid_out)
    else $error("read got no completion");
  a_iowr_done: assert property (fin && one && typ_q == 4'h3 |-> ##[1:40] compl_done_out)
    else $error("io write got no completion");
  a_wr_pend: assert property (fin && one && typ_q == 4'h1 |-> ##[1:4] write_pending_out)
    else $error("write never started");
  a_pend_stall: assert property (write_pending_out |-> !request_stream_accept_out)
    else $error("accept high while write pending");
  a_drop_quiet: assert property (fin && !one |=> !cpl_valid_out [*8])
    else $error("completion for long request");
  a_cpl_hold: assert property (cpl_valid_out && !cpl_ready_in |=> cpl_valid_out && $stable(cpl_data_out))
    else $error("completion beat changed while stalled");
  c_read: cover property (fin && one && rdk);
  c_write: cover property (write_pending_out);
  c_drop: cover property (fin && !one);
endmodule
bind ppt_target ppt_target_chk u_chk (.mclk_in, .reset_in, .req_data_in, .req_valid_in, .req_last_in,
  .request_stream_accept_out, .cpl_data_out, .cpl_valid_out, .cpl_ready_in, .compl_done_out, .write_pending_out);
`default_nettype wire

// File: testbench/ppt_core_model.sv
// behavioural endpoint core: request source and completion sink
// assumes the bench calls send and sets slow_in between requests
`default_nettype none
module ppt_core_model (
  input  wire logic        mclk_in,
  input  wire logic        accept_in,
  input  wire logic        cpl_valid_in,
  input  wire logic        cpl_last_in,
  input  wire logic [63:0] cpl_data_in,
  input  wire logic        slow_in,
  output logic [63:0]      req_data_out,
  output logic             req_valid_out,
  output logic             req_last_out,
  output logic             cpl_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cpl_n = 0;
  logic [31:0] got;
  logic [11:0] hdr;
  initial begin
    req_valid_out = 1'b0;
    req_last_out = 1'b0;
    req_data_out = 64'h0;
    cpl_ready_out = 1'b1;
  end
  always @(negedge mclk_in) cpl_ready_out <= slow_in ? ~cpl_ready_out : 1'b1;
  always @(posedge mclk_in) begin
    if (cpl_valid_in && cpl_ready_out && cpl_last_in) begin
      got <= cpl_data_in[31:0];
      cpl_n <= cpl_n + 1;
    end
    if (cpl_valid_in && cpl_ready_out && !cpl_last_in) begin
      hdr <= cpl_data_in[11:0];
    end
  end
  // a beat holds until an edge samples accept high
  task automatic put(input logic [63:0] d, input logic l);
    @(negedge mclk_in);
    req_valid_out = 1'b1;
    req_data_out = d;
    req_last_out = l;
    @(posedge mclk_in);
    while (!accept_in) @(posedge mclk_in);
  endtask
  // only bar-matched requests, index in descriptor bits 114:112
  task automatic send(input logic [3:0] t, input logic [2:0] bar, input logic [8:0] a,
                      input logic [10:0] len, input logic [31:0] d);
    put({53'h0, a, 2'h0}, 1'b0);
    put({13'h0, bar, 8'h0, 8'h5a, 17'h0, t, len}, 1'b0);
    for (int i = 1; i <= len; i++) put({32'h0, d}, i == len);
    @(negedge mclk_in);
    req_valid_out = 1'b0;
    req_last_out = 1'b0;
    req_data_out = ~req_data_out;
  endtask
endmodule
`default_nettype wire

// File: testbench/ppt_target_bench.sv
// self-checking bench for the programmed-io target
// assumes the core model drives requests and sinks completions
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin fail_count++; \
  $display("BAD %s exp %h saw %h", nm, ex, gt); end end
module ppt_target_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        slow = 1'b0;
  logic        toff_req = 1'b0;
  logic        toff_ok;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [63:0] rq_d, cp_d;
  logic        rq_v, rq_l, acc, cp_v, cp_l, cp_r, done, wpend;
  always #2 mclk_in = ~mclk_in;
  ppt_target u_dut (.mclk_in(mclk_in), .reset_in(reset_in), .req_data_in(rq_d), .req_valid_in(rq_v),
    .req_last_in(rq_l), .request_stream_accept_out(acc), .cpl_data_out(cp_d), .cpl_valid_out(cp_v),
    .cpl_last_out(cp_l), .cpl_ready_in(cp_r), .compl_done_out(done), .write_pending_out(wpend),
    .turnoff_req_in(toff_req), .turnoff_ok_out(toff_ok));
  ppt_core_model u_core (.mclk_in(mclk_in), .accept_in(acc), .cpl_valid_in(cp_v), .cpl_last_in(cp_l),
    .cpl_data_in(cp_d), .slow_in(slow), .req_data_out(rq_d), .req_valid_out(rq_v), .req_last_out(rq_l),
    .cpl_ready_out(cp_r));
  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // bound well above the longest scenario
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic wait_cpl(input int n);
    for (int k = 0; k < 80 && u_core.cpl_n < n; k++) @(posedge mclk_in);
    `CHK("completions", n, u_core.cpl_n)
  endtask
  task automatic rd(input logic [3:0] t, input logic [2:0] bar, input logic [31:0] e);
    int n;
    n = u_core.cpl_n + 1;
    u_core.send(t, bar, 9'h005, 11'h001, 32'h0);
    wait_cpl(n);
    `CHK("read data", e, u_core.got)
    `CHK("read header", (t == 4'h2) ? 12'hc01 : 12'h401, u_core.hdr)
  endtask
  task automatic t_idle();
    @(negedge mclk_in);
    toff_req = 1'b1;
    #1;
    `CHK("turnoff ok", 1'b1, toff_ok)
    toff_req = 1'b0;
    `CHK("accept", 1'b1, acc)
    `CHK("cpl valid", 1'b0, cp_v)
    `CHK("done", 1'b0, done)
  endtask
  task automatic t_regions();
    logic [2:0] bars [4] = '{3'h0, 3'h2, 3'h1, 3'h6};
    foreach (bars[i]) u_core.send(4'h1, bars[i], 9'h005, 11'h001, 32'hc0de_0000 + 32'(i));
    slow = 1'b1;
    foreach (bars[i]) rd(4'h0, bars[i], 32'hc0de_0000 + 32'(i));
    slow = 1'b0;
  endtask
  // io write then two reads back to back, last addressable word
  task automatic t_io();
    int n;
    n = u_core.cpl_n;
    u_core.send(4'h3, 3'h0, 9'h1ff, 11'h001, 32'h1234_abcd);
    toff_req = 1'b1;
    #1;
    `CHK("turnoff busy", 1'b0, toff_ok)
    toff_req = 1'b0;
    wait_cpl(n + 1);
    `CHK("iowr header", 12'h801, u_core.hdr)
    u_core.send(4'h2, 3'h0, 9'h1ff, 11'h001, 32'h0);
    u_core.send(4'h0, 3'h0, 9'h1ff, 11'h001, 32'h0);
    wait_cpl(n + 3);
    `CHK("io data", 32'h1234_abcd, u_core.got)
  endtask
  task automatic t_drop();
    int n;
    n = u_core.cpl_n;
    u_core.send(4'h1, 3'h2, 9'h005, 11'h002, 32'hdead_0000);
    u_core.send(4'h0, 3'h2, 9'h005, 11'h002, 32'h0);
    repeat (20) @(posedge mclk_in);
    `CHK("dropped cpl", n, u_core.cpl_n)
    rd(4'h0, 3'h2, 32'hc0de_0001);
  endtask
  task automatic t_rst2();
    u_core.send(4'h0, 3'h0, 9'h005, 11'h001, 32'h0);
    reset_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    reset_in = 1'b0;
    t_idle();
    rd(4'h0, 3'h0, 32'hc0de_0000);
  endtask
  initial begin
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in);
    reset_in = 1'b0;
    t_idle();
    t_regions();
    t_io();
    t_drop();
    t_rst2();
    give_verdict();
  end
endmodule
`default_nettype wire
